// >>> design/bct_pkg.sv
// Package: register map, field layout, reset values and timing for the test unit
package bct_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CHAN_ADDR = 8'h35;
  localparam logic [7:0] IDX_TEST_TIMER = 8'h37;
  localparam logic [7:0] IDX_TEST_CTRL = 8'h38;
  localparam logic [7:0] IDX_SEND_PAT = 8'h39;
  localparam logic [7:0] IDX_RECV_PAT = 8'h3a;
  localparam logic [7:0] IDX_TIM_HIGH = 8'h3b;
  localparam logic [7:0] IDX_TIM_LOW = 8'h3c;
  localparam logic [7:0] IDX_STATUS = 8'h3d;
  localparam logic [7:0] IDX_TIM_COUNT = 8'h3e;

  // Reset values
  localparam logic [7:0] RST_TEST_CTRL = 8'h00;
  localparam logic [7:0] RST_PATTERN = 8'h55;
  localparam logic [7:0] RST_TIMER_LOAD = 8'h00;
  localparam logic [4:0] RST_CHAN_ADDR = 5'h00;

  // Test channel control fields
  localparam int unsigned B_FREEZE = 7;
  localparam int unsigned B_NLP_BYPASS = 6;
  localparam int unsigned B_ATT_OFF = 5;
  localparam int unsigned B_SILENCE_OFF = 4;
  localparam int unsigned B_CHAN_ON = 3;
  localparam int unsigned B_LAW_SELECT = 2;
  localparam int unsigned B_DELAY_HI = 1;
  localparam int unsigned B_DELAY_LO = 0;
  // Pattern registers: mode bit on top, amplitude below
  localparam int unsigned B_GEN_MODE = 7;
  // Test and timer control fields
  localparam int unsigned B_SELF_TEST = 1;
  localparam int unsigned B_TIMER_RUN = 0;
  // Status fields
  localparam int unsigned B_ST_CHAN_STATE = 0;
  localparam int unsigned B_ST_ABORT = 1;
  localparam int unsigned B_ST_TIMER_RUN = 2;

  // End echo delay: code 00 means four sample periods
  localparam logic [2:0] DELAY_BASE = 3'h4;

  // Generator modes
  typedef enum logic [1:0] {
    BCT_GEN_2105 = 2'b00,
    BCT_GEN_2105_INV = 2'b01,
    BCT_GEN_2010 = 2'b10,
    BCT_GEN_RANDOM = 2'b11
  } bct_gen_mode_t;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TIMER_TICK_NS = 1000000;
  localparam int unsigned SAMPLE_NS = 125000;
  localparam int unsigned MS_CYCLES =
    (TIMER_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SAMPLE_CYCLES = SAMPLE_NS / CLK_PERIOD_NS;
  // Phase steps per 8 kHz sample for a 16-bit accumulator
  localparam logic [15:0] STEP_2105 = 16'h435c;
  localparam logic [15:0] STEP_2010 = 16'h4052;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage

// >>> design/bct_top.sv
// Background channel test unit: registers, test pattern generator, ms timer
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - External enable during test raises abort interrupt.
// - Freeze bit freezes speech unit and coefficients.
// - Bypass bit skips nonlinear processor in test.
// - Attenuator off bit disables output attenuator.
// - Silence bit turns off no-speech detection.
// - Channel on enables; off resets coefficients, meters.
// - Law bit: one A-law, zero mu-law.
// - Echo delay codes give 4..7 sample periods.
// - Tested channel ignores all external control.
// - Send pattern: top bit mode hi, amplitude.
// - Receive pattern: top bit mode lo, amplitude.
// - Sign follows 2105, inverted, 2010, random.
// - Timer counts down once per millisecond.
// - Up to 65535 ms, never early.
// - Load value from high and low bytes.
// - Self test enable runs test on addressed channel.
module bct_top #(
  parameter int unsigned NUM_CHANNELS = 32,
  parameter int unsigned MS_CYCLES = bct_pkg::MS_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Enabled state of each channel as set by external sources
  input wire logic [NUM_CHANNELS-1:0] ext_chan_enabled,
  // Controls to the channel datapath
  output logic test_active,
  output logic [4:0] test_channel,
  output logic ext_ctrl_ignore,
  output logic test_freeze,
  output logic test_nonlinear_bypass,
  output logic test_attenuator_off,
  output logic test_silence_detect_off,
  output logic test_channel_on,
  output logic coef_reset,
  output logic test_law_select,
  output logic [2:0] test_echo_delay,
  // Generated pattern: sign on top, log amplitude below
  output logic [7:0] send_pattern,
  output logic [7:0] recv_pattern,
  output logic pattern_strobe,
  output logic abort_irq
);
  // Software-visible state
  logic [7:0] test_ctrl; // Test channel control
  logic [7:0] send_cfg; // Send pattern configuration
  logic [7:0] recv_cfg; // Receive pattern configuration
  logic [7:0] tim_high; // Timer load high byte
  logic [7:0] tim_low; // Timer load low byte
  logic [4:0] test_channel_address; // Channel under test
  logic self_test_enable;
  logic timer_run;
  logic [15:0] timer_count;
  logic [$clog2(MS_CYCLES)-1:0] ms_div;
  logic [11:0] smp_div;
  logic [15:0] phase;
  logic [15:0] lfsr;
  logic sign_bit;
  logic chan_ext_on; // Selected channel enabled from outside
  logic wr_fire;
  logic [7:0] wr_idx;
  logic [7:0] wr_byte;
  logic tim_start; // Write that sets the run bit
  logic ms_tick;
  bct_pkg::bct_gen_mode_t gen_mode;

  // Index from a byte address; low two bits ignored
  function automatic logic [7:0] reg_index(input logic [31:0] addr);
    reg_index = addr[9:2];
  endfunction

  // Whether an index is mapped
  function automatic logic idx_mapped(input logic [7:0] idx);
    idx_mapped = (idx == bct_pkg::IDX_CHAN_ADDR) ||
      (idx == bct_pkg::IDX_TEST_TIMER) ||
      (idx >= bct_pkg::IDX_TEST_CTRL && idx <= bct_pkg::IDX_TIM_COUNT);
  endfunction

  assign wr_idx = reg_index(s_axi_awaddr);
  assign wr_byte = s_axi_wdata[7:0];
  // Both channels present and taken this edge
  assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign tim_start = wr_fire && s_axi_wstrb[0] &&
    (wr_idx == bct_pkg::IDX_TEST_TIMER) && wr_byte[bct_pkg::B_TIMER_RUN];
  assign chan_ext_on = ext_chan_enabled[test_channel_address];
  // Mode hi from send register, mode lo from receive register
  assign gen_mode = bct_pkg::bct_gen_mode_t'({send_cfg[bct_pkg::B_GEN_MODE],
    recv_cfg[bct_pkg::B_GEN_MODE]});
  assign ms_tick = (ms_div == '0);

  // Write address and data are taken together, one write at a time;
  // holding both ready low until both valid avoids a half-taken write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
        !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
        !s_axi_bvalid;
    end
  end

  // Write response one cycle after the take
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bct_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= idx_mapped(wr_idx) ? bct_pkg::RESP_OKAY :
        bct_pkg::RESP_DECERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; only byte lane 0 carries data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      test_ctrl <= bct_pkg::RST_TEST_CTRL;
      send_cfg <= bct_pkg::RST_PATTERN;
      recv_cfg <= bct_pkg::RST_PATTERN;
      tim_high <= bct_pkg::RST_TIMER_LOAD;
      tim_low <= bct_pkg::RST_TIMER_LOAD;
      test_channel_address <= bct_pkg::RST_CHAN_ADDR;
      self_test_enable <= 1'b0;
    end
    else if (wr_fire && s_axi_wstrb[0])
    begin
      unique case (wr_idx)
        bct_pkg::IDX_CHAN_ADDR: test_channel_address <= wr_byte[4:0];
        // Only clearing this bit ends a running test
        bct_pkg::IDX_TEST_TIMER:
          self_test_enable <= wr_byte[bct_pkg::B_SELF_TEST];
        bct_pkg::IDX_TEST_CTRL: test_ctrl <= wr_byte;
        bct_pkg::IDX_SEND_PAT: send_cfg <= wr_byte;
        bct_pkg::IDX_RECV_PAT: recv_cfg <= wr_byte;
        bct_pkg::IDX_TIM_HIGH: tim_high <= wr_byte;
        bct_pkg::IDX_TIM_LOW: tim_low <= wr_byte;
        default: ;
      endcase
    end
  end

  // Read channel: one read at a time, data one cycle after the take
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= bct_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= idx_mapped(reg_index(s_axi_araddr)) ?
          bct_pkg::RESP_OKAY : bct_pkg::RESP_DECERR;
        s_axi_rdata <= 32'h0000_0000;
        unique case (reg_index(s_axi_araddr))
          bct_pkg::IDX_CHAN_ADDR: s_axi_rdata[4:0] <= test_channel_address;
          bct_pkg::IDX_TEST_TIMER:
            s_axi_rdata[1:0] <= {self_test_enable, timer_run};
          bct_pkg::IDX_TEST_CTRL: s_axi_rdata[7:0] <= test_ctrl;
          bct_pkg::IDX_SEND_PAT: s_axi_rdata[7:0] <= send_cfg;
          bct_pkg::IDX_RECV_PAT: s_axi_rdata[7:0] <= recv_cfg;
          bct_pkg::IDX_TIM_HIGH: s_axi_rdata[7:0] <= tim_high;
          bct_pkg::IDX_TIM_LOW: s_axi_rdata[7:0] <= tim_low;
          // Channel state lets software check before it starts a test
          bct_pkg::IDX_STATUS:
            s_axi_rdata[2:0] <= {timer_run, abort_irq, chan_ext_on};
          bct_pkg::IDX_TIM_COUNT: s_axi_rdata[15:0] <= timer_count;
          default: ;
        endcase
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Datapath controls, registered so each output is a flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      test_active <= 1'b0;
      test_channel <= bct_pkg::RST_CHAN_ADDR;
      ext_ctrl_ignore <= 1'b0;
      test_freeze <= 1'b0;
      test_nonlinear_bypass <= 1'b0;
      test_attenuator_off <= 1'b0;
      test_silence_detect_off <= 1'b0;
      test_channel_on <= 1'b0;
      coef_reset <= 1'b0;
      test_law_select <= 1'b0;
      test_echo_delay <= bct_pkg::DELAY_BASE;
    end
    else
    begin
      test_active <= self_test_enable;
      test_channel <= test_channel_address;
      ext_ctrl_ignore <= self_test_enable;
      test_freeze <= self_test_enable &&
        test_ctrl[bct_pkg::B_FREEZE];
      test_nonlinear_bypass <= self_test_enable &&
        test_ctrl[bct_pkg::B_NLP_BYPASS];
      // Low leaves the attenuator to the normal PCM configuration
      test_attenuator_off <= self_test_enable &&
        test_ctrl[bct_pkg::B_ATT_OFF];
      test_silence_detect_off <= self_test_enable &&
        test_ctrl[bct_pkg::B_SILENCE_OFF];
      test_channel_on <= self_test_enable &&
        test_ctrl[bct_pkg::B_CHAN_ON];
      // Level reset: held as long as a test runs with the channel off
      coef_reset <= self_test_enable &&
        !test_ctrl[bct_pkg::B_CHAN_ON];
      test_law_select <= test_ctrl[bct_pkg::B_LAW_SELECT];
      test_echo_delay <= bct_pkg::DELAY_BASE +
        {1'b0, test_ctrl[bct_pkg::B_DELAY_HI:bct_pkg::B_DELAY_LO]};
    end
  end

  // Abort flag: set while a test runs with the channel on outside, cleared once the test ends
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      abort_irq <= 1'b0;
    end
    else if (self_test_enable && chan_ext_on)
    begin
      abort_irq <= 1'b1;
    end
    else if (!self_test_enable)
    begin
      abort_irq <= 1'b0;
    end
  end

  // Sample-rate divider for the 125 us generator step
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      smp_div <= '0;
      pattern_strobe <= 1'b0;
    end
    else
    begin
      pattern_strobe <= (smp_div == 12'(bct_pkg::SAMPLE_CYCLES - 1));
      if (smp_div == 12'(bct_pkg::SAMPLE_CYCLES - 1))
        smp_div <= '0;
      else
        smp_div <= smp_div + 12'h001;
    end
  end

  // Phase accumulator and random source, one step per sample
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase <= '0;
      lfsr <= bct_pkg::LFSR_SEED;
    end
    else if (smp_div == '0)
    begin
      phase <= phase + ((gen_mode == bct_pkg::BCT_GEN_2010) ?
        bct_pkg::STEP_2010 : bct_pkg::STEP_2105);
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  // Sign of the rectified pattern by mode
  always_comb
  begin
    unique case (gen_mode)
      bct_pkg::BCT_GEN_2105: sign_bit = phase[15];
      bct_pkg::BCT_GEN_2105_INV: sign_bit = !phase[15];
      bct_pkg::BCT_GEN_2010: sign_bit = phase[15];
      bct_pkg::BCT_GEN_RANDOM: sign_bit = lfsr[0];
    endcase
  end

  // Pattern words: same sign, amplitude per path
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      send_pattern <= 8'h00;
      recv_pattern <= 8'h00;
    end
    else
    begin
      send_pattern <= {sign_bit, send_cfg[6:0]};
      recv_pattern <= {sign_bit, recv_cfg[6:0]};
    end
  end

  // Millisecond prescaler restarts on a start write so the first tick
  // comes a full millisecond later: expiry is never early
  always_ff @(posedge aclk)
  begin
    if (!aresetn || tim_start || !timer_run)
      ms_div <= $bits(ms_div)'(MS_CYCLES - 1);
    else if (ms_tick)
      ms_div <= $bits(ms_div)'(MS_CYCLES - 1);
    else
      ms_div <= ms_div - 1'b1;
  end

  // Timer: load on start, count down per ms, stop at zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_run <= 1'b0;
      timer_count <= 16'h0000;
    end
    else if (wr_fire && s_axi_wstrb[0] && wr_idx == bct_pkg::IDX_TEST_TIMER)
    begin
      timer_run <= wr_byte[bct_pkg::B_TIMER_RUN];
      if (wr_byte[bct_pkg::B_TIMER_RUN])
        timer_count <= {tim_high, tim_low};
    end
    else if (timer_run && ms_tick)
    begin
      if (timer_count <= 16'h0001)
      begin
        timer_count <= 16'h0000;
        timer_run <= 1'b0;
      end
      else
        timer_count <= timer_count - 16'h0001;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Named steps of a write and a timer start
  sequence s_write_taken;
    s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  endsequence
  sequence s_timer_started;
    tim_start;
  endsequence

  a_write_resp: assert property (s_write_taken |=> s_axi_bvalid)
    else $error("write response missing");
  a_abort_raise:
    assert property (self_test_enable && chan_ext_on |=> abort_irq)
    else $error("abort not raised");
  a_abort_end:
    assert property (abort_irq && !self_test_enable &&
    !chan_ext_on |=> !abort_irq)
    else $error("abort stays after test end");
  a_freeze_follow:
    assert property (test_freeze |->
    $past(test_ctrl[bct_pkg::B_FREEZE]) && test_active)
    else $error("freeze without cause");
  a_coef_reset:
    assert property (self_test_enable &&
    !test_ctrl[bct_pkg::B_CHAN_ON] |=> coef_reset && !test_channel_on)
    else $error("channel off without coefficient reset");
  a_delay_units:
    assert property (##1 test_echo_delay ==
    3'(4 + $past(test_ctrl[1:0])))
    else $error("echo delay code wrong");
  a_timer_load:
    assert property (s_timer_started |=>
    timer_count == $past({tim_high, tim_low}) && timer_run)
    else $error("timer not loaded");
  a_timer_step:
    assert property (timer_run && ms_tick && !tim_start &&
    !wr_fire && timer_count > 16'h0001
    |=> timer_count == $past(timer_count) - 16'h0001)
    else $error("timer step wrong");
  a_timer_zero:
    assert property (!timer_run && timer_count == 16'h0000 &&
    !tim_start |=> timer_count == 16'h0000)
    else $error("timer left zero");
  a_ignore_ext:
    assert property (self_test_enable |=> ext_ctrl_ignore)
    else $error("external control not blocked");
endmodule

`default_nettype wire

// >>> testbench/bct_testbench.sv
// Self-checking bench for the background channel test unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int MS = 20; // Shortened millisecond keeps the run brief
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [31:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [31:0] ext_chan_enabled = '0; // External enables per channel
  logic test_active, ext_ctrl_ignore, test_freeze, test_nonlinear_bypass;
  logic test_attenuator_off, test_silence_detect_off, test_channel_on;
  logic coef_reset, test_law_select, pattern_strobe, abort_irq;
  logic [4:0] test_channel;
  logic [2:0] test_echo_delay;
  logic [7:0] send_pattern, recv_pattern;
  int error_cnt = 0;
  int tests_run = 0;
  int seed = 32'hed0e;
  int n;
  logic [4:0] ch; // Channel under test
  logic [7:0] c; // Model of the control byte
  logic [15:0] tl; // Model of the timer load value
  logic [7:0] sa, ra; // Model of the pattern bytes

  bct_top #(.NUM_CHANNELS(32), .MS_CYCLES(MS)) i_bct_top (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ext_chan_enabled, .test_active, .test_channel,
    .ext_ctrl_ignore, .test_freeze, .test_nonlinear_bypass,
    .test_attenuator_off, .test_silence_detect_off, .test_channel_on,
    .coef_reset, .test_law_select, .test_echo_delay, .send_pattern,
    .recv_pattern, .pattern_strobe, .abort_irq);

  // Free running 25 MHz clock
  initial
  begin
    forever #20 aclk = ~aclk;
  end

  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Report the counts, give the verdict and stop
  task automatic print_verdict;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard: the sequence needs well under this many cycles
  initial
  begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    print_verdict();
  end

  // Let k edges pass, then park on a falling edge where outputs are settled
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
    @(negedge aclk);
  endtask

  // Write one word; ready is looked at on the falling edge, which shows
  // the level that the next rising edge samples
  task automatic axw(input logic [7:0] idx, input logic [7:0] d,
                     input logic [1:0] er);
    int k;
    logic aw;
    logic w;
    k = 0;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while ((aw || w) && k < 200)
    begin
      @(negedge aclk);
      k++;
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      @(posedge aclk);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(negedge aclk); while (!s_axi_bvalid && ++k < 400);
    chk("bresp", s_axi_bresp, er);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  // Read one word and compare data and response
  task automatic rchk(input logic [7:0] idx, input logic [31:0] ed,
                      input logic [1:0] er);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready && ++k < 200);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid && ++k < 400);
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", s_axi_rresp, er);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(1);
    chk("delay", test_echo_delay, 3'h4);
    // Reset values of the five table registers, then a hole in the map
    for (int i = 0; i < 5; i++)
      rchk(8'h38 + 8'(i), (i == 1 || i == 2) ? 32'h55 : 32'h0, 2'b00);
    rchk(8'h00, 32'h0, 2'b11);
    axw(8'h00, 8'hff, 2'b11);
    ch = 5'($random(seed));
    axw(8'h35, {3'h0, ch}, 2'b00);
    // Every delay code, both law settings, channel on and off
    for (int i = 0; i < 4; i++)
    begin
      c = 8'($random(seed));
      c[3:0] = {i[0], i[1], i[1:0]};
      axw(8'h38, c, 2'b00);
      ext_chan_enabled <= 32'($random(seed)) & ~(32'h1 << ch);
      axw(8'h37, 8'h02, 2'b00);
      cyc(2);
      chk("active", {test_active, test_channel}, {1'b1, ch});
      chk("ignore", ext_ctrl_ignore, 1'b1);
      chk("ctl", {test_freeze, test_nonlinear_bypass, test_attenuator_off,
        test_silence_detect_off, test_channel_on, test_law_select},
        c[7:2]);
      chk("coef", coef_reset, !c[3]);
      chk("delay", test_echo_delay, 3'h4 + c[1:0]);
      chk("abort", abort_irq, 1'b0);
      rchk(8'h3d, 32'h0, 2'b00);
      rchk(8'h38, {24'h0, c}, 2'b00);
      axw(8'h37, 8'h00, 2'b00);
      cyc(2);
      chk("off", {test_active, ext_ctrl_ignore, test_freeze, coef_reset,
        test_channel_on}, 5'h0);
      chk("law", test_law_select, c[2]);
    end
    // Channel turns enabled from outside during a test
    axw(8'h37, 8'h02, 2'b00);
    ext_chan_enabled[ch] <= 1'b1;
    cyc(3);
    chk("abort", abort_irq, 1'b1);
    rchk(8'h3d, 32'h3, 2'b00);
    axw(8'h37, 8'h00, 2'b00);
    ext_chan_enabled[ch] <= 1'b0;
    cyc(3);
    chk("abort", abort_irq, 1'b0);
    // Timer load from both bytes, then a stop that keeps the count
    tl = 16'($random(seed));
    tl[15] = 1'b1;
    axw(8'h3b, tl[15:8], 2'b00);
    axw(8'h3c, tl[7:0], 2'b00);
    axw(8'h37, 8'h01, 2'b00);
    rchk(8'h3e, {16'h0, tl}, 2'b00);
    axw(8'h37, 8'h00, 2'b00);
    cyc(2 * MS);
    rchk(8'h3e, {16'h0, tl}, 2'b00);
    // Short interval: never early, one step a millisecond, holds zero
    axw(8'h3b, 8'h00, 2'b00);
    axw(8'h3c, 8'h05, 2'b00);
    axw(8'h37, 8'h01, 2'b00);
    rchk(8'h3e, 32'h5, 2'b00);
    rchk(8'h3d, 32'h4, 2'b00);
    cyc(2 * MS);
    rchk(8'h3e, 32'h3, 2'b00);
    cyc(4 * MS);
    rchk(8'h3e, 32'h0, 2'b00);
    rchk(8'h3d, 32'h0, 2'b00);
    // Test and timer started by one write, as software should do it
    axw(8'h37, 8'h03, 2'b00);
    cyc(2);
    chk("both", test_active, 1'b1);
    rchk(8'h37, 32'h3, 2'b00);
    rchk(8'h3d, 32'h4, 2'b00);
    axw(8'h37, 8'h00, 2'b00);
    // All four generator modes; amplitude follows the low seven bits
    for (int m = 0; m < 4; m++)
    begin
      sa = {m[1], 7'($random(seed))};
      ra = {m[0], 7'($random(seed))};
      axw(8'h39, sa, 2'b00);
      axw(8'h3a, ra, 2'b00);
      rchk(8'h39, {24'h0, sa}, 2'b00);
      rchk(8'h3a, {24'h0, ra}, 2'b00);
      cyc(2);
      chk("samp", send_pattern[6:0], sa[6:0]);
      chk("ramp", recv_pattern[6:0], ra[6:0]);
      // One sign drives both paths
      chk("sign", send_pattern[7], recv_pattern[7]);
    end
    // Pattern strobe repeats at the 8 kHz sample rate
    n = 0;
    do @(negedge aclk); while (!pattern_strobe && ++n < 4000);
    n = 0;
    do @(negedge aclk); while (!pattern_strobe && ++n < 4000);
    chk("period", 32'(n + 1), 125000 / 40);
    print_verdict();
  end
endmodule
`default_nettype wire
